// File: hdl/ftc_consts.svh
`ifndef FTC_CONSTS_SVH
`define FTC_CONSTS_SVH

`define FTC_NUM_ENTRIES 32
`define FTC_NUM_BUILTIN 4
`define FTC_NUM_ADDON 32
`define FTC_NUM_PINS 36
`define FTC_ADDR_W 12

// Clock and time base
`define FTC_CLK_PERIOD_NS 25
`define FTC_US_NS 1000
`define FTC_US_CYCLES (`FTC_US_NS / `FTC_CLK_PERIOD_NS)
`define FTC_OP_CYCLE_US 1000

// Detection accuracy grids in microseconds
`define FTC_BUILTIN_ACC_US 9'd30
`define FTC_ADDON_ACC_04_US 9'd69
`define FTC_ADDON_ACC_06_US 9'd133
`define FTC_ADDON_ACC_10_US 9'd261
`define FTC_FILT_04 2'h0
`define FTC_FILT_06 2'h1

// Compensation limits in microseconds
`define FTC_COMP_MAX 32'sh004c4b40
`define FTC_COMP_MIN -32'sh004c4b40

// Register byte offsets and bank numbers
`define FTC_OFF_CTRL 12'h000
`define FTC_OFF_VALID 12'h004
`define FTC_OFF_VALID_USED 12'h008
`define FTC_OFF_EDGE_DIR 12'h00c
`define FTC_OFF_EXT_BASE 12'h010
`define FTC_OFF_IN_STATUS 12'h014
`define FTC_OFF_EVT_STATUS 12'h018
`define FTC_OFF_EVT_MASK 12'h01c
`define FTC_OFF_US_TIME 12'h020
`define FTC_BANK_COMP 5'h01
`define FTC_BANK_CFG 5'h02

// Field positions
`define FTC_CTRL_EN 0
`define FTC_CTRL_FILT_LSB 1
`define FTC_CFG_ACT_LSB 0
`define FTC_CFG_BUILTIN 3
`define FTC_CFG_SRC_LSB 4
`define FTC_CFG_W 9
`define FTC_BUILTIN_FIRST 5'h01
`define FTC_BUILTIN_LAST 5'h04

`endif

// File: hdl/ftc_pkg.sv
package ftc_pkg;

   typedef enum logic [2:0] {
      ftc_act_none = 3'h0,
      ftc_act_clutch_on = 3'h1,
      ftc_act_clutch_off = 3'h2,
      ftc_act_enc_enable = 3'h3,
      ftc_act_enc_disable = 3'h4,
      ftc_act_enc_change = 3'h5
   } ftc_action_t;

   typedef logic [31:0] ftc_word_t;

endpackage : ftc_pkg

// File: hdl/ftc_pin_sync.sv
`timescale 1ns/1ps
module ftc_pin_sync #(
   parameter int W = 36
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] pins_i,
   input wire logic [W-1:0] sample_en_i,
   output logic [W-1:0] synced_o,
   output logic [W-1:0] sampled_o
);

   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         synced_o <= '0;
      end else begin
         meta <= pins_i;
         synced_o <= meta;
      end
   end

   // Hold each level between its accuracy ticks
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_smp
         always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sampled_o[g] <= 1'b0;
            end else if (sample_en_i[g]) begin
               sampled_o[g] <= synced_o[g];
            end
         end
      end
   endgenerate

endmodule : ftc_pin_sync

// File: hdl/ftc_capture.sv
`timescale 1ns/1ps
`include "ftc_consts.svh"
module ftc_capture
   import ftc_pkg::*;
#(
   parameter int OP_CYCLE_CYCLES = `FTC_OP_CYCLE_US * `FTC_US_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`FTC_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [`FTC_NUM_BUILTIN-1:0] builtin_digital_input_i,
   input wire logic [15:0] tracking_trigger_input_i,
   input wire logic [15:0] proximity_change_input_i,
   input wire logic sync_control_active_status_i,
   input wire logic encoder_axis_control_request_i,
   output logic evt_valid_o,
   output logic [4:0] evt_entry_o,
   output ftc_action_t evt_action_o,
   output logic [31:0] evt_time_o,
   output logic op_cycle_o,
   output logic irq_o
);
   localparam int N = `FTC_NUM_ENTRIES;
   localparam int P = `FTC_NUM_PINS;
   localparam logic [5:0] US_LAST = 6'(`FTC_US_CYCLES - 1);
   localparam logic [31:0] OP_LAST = 32'(OP_CYCLE_CYCLES - 1);
   function automatic logic [4:0] word_index(input logic [11:0] a);
      word_index = a[6:2];
   endfunction : word_index
   function automatic logic [31:0] sat_comp(input logic signed [31:0] v);
      if (v > `FTC_COMP_MAX) begin
         sat_comp = `FTC_COMP_MAX;
      end else if (v < `FTC_COMP_MIN) begin
         sat_comp = `FTC_COMP_MIN;
      end else begin
         sat_comp = v;
      end
   endfunction : sat_comp
   logic ctrl_en;
   logic [1:0] filt_sel;
   logic [N-1:0] valid_flag;
   logic [N-1:0] valid_used;
   logic [N-1:0] edge_dir;
   logic [N-1:0] ext_base;
   logic [N-1:0] in_status;
   logic [N-1:0] evt_status;
   logic [N-1:0] evt_mask;
   logic [31:0] comp_reg [N];
   logic [31:0] comp_app [N];
   logic [`FTC_CFG_W-1:0] cfg [N];
   logic [31:0] stamp [N];
   logic [N-1:0] pend;
   // Time base
   logic [5:0] us_div;
   logic us_tick;
   logic [31:0] us_time;
   logic [8:0] acc_b_cnt;
   logic [8:0] acc_a_cnt;
   logic [8:0] acc_a_last;
   logic tick_b;
   logic tick_a;
   logic [31:0] op_cnt;
   logic op_tick;
   assign us_tick = (us_div == US_LAST);
   assign op_tick = (op_cnt == OP_LAST);
   assign tick_b = us_tick && (acc_b_cnt == `FTC_BUILTIN_ACC_US - 9'd1);
   assign acc_a_last = (filt_sel == `FTC_FILT_04) ? `FTC_ADDON_ACC_04_US :
                       (filt_sel == `FTC_FILT_06) ? `FTC_ADDON_ACC_06_US :
                       `FTC_ADDON_ACC_10_US;
   assign tick_a = us_tick && (acc_a_cnt >= acc_a_last - 9'd1);
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         us_div <= '0;
         us_time <= '0;
         acc_b_cnt <= '0;
         acc_a_cnt <= '0;
         op_cnt <= '0;
      end else begin
         us_div <= us_tick ? 6'h00 : us_div + 6'h01;
         us_time <= us_time + {31'h0, us_tick};
         if (us_tick) begin
            acc_b_cnt <= tick_b ? 9'h000 : acc_b_cnt + 9'h001;
            acc_a_cnt <= tick_a ? 9'h000 : acc_a_cnt + 9'h001;
         end
         op_cnt <= op_tick ? 32'h0 : op_cnt + 32'h1;
      end
   end

   // Pins
   logic [P-1:0] pins;
   logic [P-1:0] smp_en;
   logic [P-1:0] lvl_sync;
   logic [P-1:0] lvl_smp;
   assign pins = {proximity_change_input_i, tracking_trigger_input_i,
                  builtin_digital_input_i};
   assign smp_en = {{`FTC_NUM_ADDON{tick_a}}, {`FTC_NUM_BUILTIN{tick_b}}};
   ftc_pin_sync #(.W(P)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pins_i(pins),
      .sample_en_i(smp_en),
      .synced_o(lvl_sync),
      .sampled_o(lvl_smp)
   );

   // Picks an entry's source from the pin vector
   function automatic logic pick(input logic [`FTC_CFG_W-1:0] c,
                                 input logic [P-1:0] v);
      logic [4:0] src;
      src = c[`FTC_CFG_SRC_LSB +: 5];
      if (c[`FTC_CFG_BUILTIN]) begin
         pick = (src >= `FTC_BUILTIN_FIRST && src <= `FTC_BUILTIN_LAST) ?
                v[src - `FTC_BUILTIN_FIRST] : 1'b0;
      end else begin
         pick = v[`FTC_NUM_BUILTIN + src];
      end
   endfunction : pick
   // APB decode
   logic wr_en;
   logic [4:0] widx;
   logic [4:0] bank;
   logic hit_comp;
   logic hit_cfg;
   logic hit_flat;
   logic mapped;
   logic [31:0] next_rdata;
   assign wr_en = psel_i && penable_i && pwrite_i && mapped;
   assign widx = word_index(paddr_i);
   assign bank = paddr_i[11:7];
   assign hit_comp = (bank == `FTC_BANK_COMP);
   assign hit_cfg = (bank == `FTC_BANK_CFG);
   assign hit_flat = (paddr_i <= `FTC_OFF_US_TIME);
   assign mapped = (paddr_i[1:0] == 2'b00) && (hit_comp || hit_cfg || hit_flat);
   // Zero wait states; read data latched in the setup cycle
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   always_comb begin
      next_rdata = 32'h0;
      if (hit_comp) begin
         next_rdata = comp_reg[widx];
      end else if (hit_cfg) begin
         next_rdata = {23'h0, cfg[widx]};
      end else if (paddr_i == `FTC_OFF_CTRL) begin
         next_rdata = {29'h0, filt_sel, ctrl_en};
      end else if (paddr_i == `FTC_OFF_VALID) begin
         next_rdata = valid_flag;
      end else if (paddr_i == `FTC_OFF_VALID_USED) begin
         next_rdata = valid_used;
      end else if (paddr_i == `FTC_OFF_EDGE_DIR) begin
         next_rdata = edge_dir;
      end else if (paddr_i == `FTC_OFF_EXT_BASE) begin
         next_rdata = ext_base;
      end else if (paddr_i == `FTC_OFF_IN_STATUS) begin
         next_rdata = in_status;
      end else if (paddr_i == `FTC_OFF_EVT_STATUS) begin
         next_rdata = evt_status;
      end else if (paddr_i == `FTC_OFF_EVT_MASK) begin
         next_rdata = evt_mask;
      end else if (paddr_i == `FTC_OFF_US_TIME) begin
         next_rdata = us_time;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= '0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= mapped ? next_rdata : 32'h0;
      end
   end

   // Per-entry detection
   logic ctl_active;
   logic [N-1:0] raw;
   logic [N-1:0] lvl;
   logic [N-1:0] prev;
   logic [N-1:0] edge_hit;
   logic [N-1:0] usable;
   logic [N-1:0] accept;
   logic [N-1:0] clr_valid;
   assign ctl_active = sync_control_active_status_i &&
                       encoder_axis_control_request_i;
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ent
         // Status taps the raw synced pin
         assign raw[g] = pick(cfg[g], lvl_sync);
         assign lvl[g] = pick(cfg[g], lvl_smp);
         assign edge_hit[g] = edge_dir[g] ? (prev[g] && !lvl[g])
                                          : (!prev[g] && lvl[g]);
         assign usable[g] = cfg[g][`FTC_CFG_BUILTIN] || !ext_base[g];
         assign accept[g] = edge_hit[g] && ctrl_en && ctl_active &&
                            usable[g] && (valid_flag[g] || !valid_used[g]);
         assign clr_valid[g] = edge_hit[g] && !ctl_active && valid_used[g];

         always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               comp_reg[g] <= '0;
               comp_app[g] <= '0;
               cfg[g] <= '0;
               stamp[g] <= '0;
            end else begin
               if (wr_en && hit_comp && widx == 5'(g)) begin
                  comp_reg[g] <= pwdata_i;
               end
               if (wr_en && hit_cfg && widx == 5'(g)) begin
                  cfg[g] <= pwdata_i[`FTC_CFG_W-1:0];
               end
               if (op_tick) begin
                  comp_app[g] <= sat_comp(comp_reg[g]);
               end
               if (accept[g]) begin
                  stamp[g] <= us_time;
               end
            end
         end
      end
   endgenerate

   // Lowest pending entry goes first
   logic [N-1:0] grant;
   logic [4:0] gidx;
   assign grant = pend & (~pend + 32'h1);
   function automatic logic [4:0] enc(input logic [N-1:0] oh);
      enc = 5'h00;
      for (int i = 0; i < N; i++) begin
         if (oh[i]) begin
            enc = 5'(i);
         end
      end
   endfunction : enc
   assign gidx = enc(grant);
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_en <= 1'b0;
         filt_sel <= 2'h0;
         valid_flag <= '0;
         valid_used <= '0;
         edge_dir <= '0;
         ext_base <= '0;
         in_status <= '0;
         evt_status <= '0;
         evt_mask <= '0;
         prev <= '0;
         pend <= '0;
      end else begin
         prev <= lvl;
         if (wr_en && paddr_i == `FTC_OFF_CTRL) begin
            ctrl_en <= pwdata_i[`FTC_CTRL_EN];
            filt_sel <= pwdata_i[`FTC_CTRL_FILT_LSB +: 2];
         end
         // Hardware clear beats a same-cycle write
         if (wr_en && paddr_i == `FTC_OFF_VALID) begin
            valid_flag <= pwdata_i & ~clr_valid;
         end else begin
            valid_flag <= valid_flag & ~clr_valid;
         end
         if (wr_en && paddr_i == `FTC_OFF_VALID_USED) begin
            valid_used <= pwdata_i;
         end
         if (wr_en && paddr_i == `FTC_OFF_EDGE_DIR) begin
            edge_dir <= pwdata_i;
         end
         if (wr_en && paddr_i == `FTC_OFF_EXT_BASE) begin
            ext_base <= pwdata_i;
         end
         if (wr_en && paddr_i == `FTC_OFF_EVT_MASK) begin
            evt_mask <= pwdata_i;
         end
         if (op_tick) begin
            in_status <= raw;
         end
         // New event wins over a write-one clear
         if (wr_en && paddr_i == `FTC_OFF_EVT_STATUS) begin
            evt_status <= (evt_status & ~pwdata_i) | accept;
         end else begin
            evt_status <= evt_status | accept;
         end
         // A repeat edge before delivery overwrites the stamp
         pend <= (pend & ~grant) | accept;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_valid_o <= 1'b0;
         evt_entry_o <= '0;
         evt_action_o <= ftc_act_none;
         evt_time_o <= '0;
      end else begin
         evt_valid_o <= |pend;
         if (|pend) begin
            evt_entry_o <= gidx;
            evt_action_o <= ftc_action_t'(cfg[gidx][`FTC_CFG_ACT_LSB +: 3]);
            evt_time_o <= stamp[gidx] - comp_app[gidx];
         end
      end
   end

   assign op_cycle_o = op_tick;
   assign irq_o = |(evt_status & evt_mask);

endmodule : ftc_capture

// File: bench/ftc_checker.sv
`timescale 1ns/1ps
module ftc_checker #(
   parameter int OP_CYCLE_CYCLES = 50
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sync_control_active_status_i,
   input wire logic evt_valid_o,
   input wire logic [4:0] evt_entry_o,
   input wire logic [31:0] evt_time_o,
   input wire logic op_cycle_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Gap counter, first tick after reset has no reference
   int gap;
   logic seen;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (op_cycle_o) begin
         gap <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   a_op_period: assert property (
      op_cycle_o && seen |-> gap == OP_CYCLE_CYCLES - 1)
      else $error("operation tick spacing wrong");
   a_op_single: assert property (
      op_cycle_o |=> !op_cycle_o)
      else $error("operation tick longer than one cycle");
   a_ready_access: assert property (
      psel_i && penable_i |-> pready_o)
      else $error("no ready in access phase");
   a_err_phase: assert property (
      pslverr_o |-> psel_i && penable_i)
      else $error("error outside access phase");
   a_err_misalign: assert property (
      psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("misaligned access not refused");
   a_err_read_zero: assert property (
      psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
      else $error("refused read returns data");
   a_evt_needs_sync: assert property (
      evt_valid_o |-> $past(sync_control_active_status_i, 2))
      else $error("event while sync control inactive");
   a_evt_data_hold: assert property (
      !evt_valid_o |-> $stable(evt_time_o) && $stable(evt_entry_o))
      else $error("event data moved without event");
endmodule : ftc_checker

bind ftc_capture ftc_checker #(
   .OP_CYCLE_CYCLES(OP_CYCLE_CYCLES)
) chk (
   .sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .prdata_o, .pready_o, .pslverr_o, .sync_control_active_status_i,
   .evt_valid_o, .evt_entry_o, .evt_time_o, .op_cycle_o
);

// File: bench/ftc_sensor_model.sv
`timescale 1ns/1ps
module ftc_sensor_model (
   input wire logic sys_clk_i,
   input wire logic [35:0] cmd_i,
   input wire logic slow_i,
   output logic [3:0] builtin_digital_input_o,
   output logic [15:0] tracking_trigger_input_o,
   output logic [15:0] proximity_change_input_o
);
   // Sensor lags the command; slow mode mimics a late sensor
   logic [35:0] pins = 36'h0;
   logic [4:0] lag = 5'h0;
   always @(posedge sys_clk_i) begin
      if (cmd_i == pins) begin
         lag <= 5'h0;
      end else if (lag >= (slow_i ? 5'h14 : 5'h01)) begin
         pins <= cmd_i;
         lag <= 5'h0;
      end else begin
         lag <= lag + 5'h1;
      end
   end
   assign builtin_digital_input_o = pins[3:0];
   assign tracking_trigger_input_o = pins[19:4];
   assign proximity_change_input_o = pins[35:20];
endmodule : ftc_sensor_model

// File: bench/fast_input_trigger_capture_bench.sv
`timescale 1ns/1ps
`include "ftc_consts.svh"
module fast_input_trigger_capture_bench
   import ftc_pkg::*;
;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd, evt_time_o;
   logic pready_o, pslverr_o, evt_valid_o, op_cycle_o, irq_o;
   logic sync_i = 1'b1, enc_i = 1'b1, slow = 1'b0;
   logic [35:0] cmd = 36'h0;
   logic [3:0] bi;
   logic [15:0] tr, px;
   logic [4:0] evt_entry_o;
   ftc_action_t evt_action_o;
   int error_cnt = 0, comparisons = 0;
   int hold = 3000;
   localparam logic [11:0] comp0 = {`FTC_BANK_COMP, 5'h00, 2'h0};
   localparam logic [11:0] cfg0 = {`FTC_BANK_CFG, 5'h00, 2'h0};
   localparam logic [11:0] cfg31 = {`FTC_BANK_CFG, 5'h1f, 2'h0};
   always #12.5 sys_clk_i = ~sys_clk_i;
   ftc_sensor_model sens (.sys_clk_i(sys_clk_i), .cmd_i(cmd),
      .slow_i(slow), .builtin_digital_input_o(bi),
      .tracking_trigger_input_o(tr), .proximity_change_input_o(px));
   ftc_capture #(.OP_CYCLE_CYCLES(50)) uut (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .builtin_digital_input_i(bi), .tracking_trigger_input_i(tr),
      .proximity_change_input_i(px),
      .sync_control_active_status_i(sync_i),
      .encoder_axis_control_request_i(enc_i),
      .evt_valid_o(evt_valid_o), .evt_entry_o(evt_entry_o),
      .evt_action_o(evt_action_o), .evt_time_o(evt_time_o),
      .op_cycle_o(op_cycle_o), .irq_o(irq_o));
   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Idle cycle after each transfer keeps strobes single-driven
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic e);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (n >= 16) begin
         error_cnt++;
         summarize();
      end
      rd = prdata_o;
      chk({31'h0, pslverr_o}, {31'h0, e});
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   task automatic wait_evt(input int lim, input logic e);
      int n;
      n = 0;
      while (evt_valid_o !== 1'b1 && n < lim) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk({31'h0, evt_valid_o}, {31'h0, e});
      if (e && n >= lim) summarize();
   endtask : wait_evt
   // Low long enough for the slowest grid in use to see it
   task trig(input int p);
      cmd[p] <= 1'b0;
      repeat (hold) @(posedge sys_clk_i);
      cmd[p] <= 1'b1;
   endtask : trig
   task automatic ev(input int p, input logic [4:0] en,
      input logic [2:0] ac, input logic [31:0] c);
      logic [31:0] t;
      trig(p);
      wait_evt(8000, 1'b1);
      t = evt_time_o;
      chk({27'h0, evt_entry_o}, {27'h0, en});
      chk({29'h0, evt_action_o}, {29'h0, ac});
      apb(1'b0, `FTC_OFF_US_TIME, 32'h0, 1'b0);
      chk({31'h0, (rd - t - c) <= 32'd2}, 32'h1);
   endtask : ev
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      apb(1'b0, `FTC_OFF_EVT_STATUS, 32'h0, 1'b0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h040, 32'h0, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h002, 32'h0, 1'b1);
      apb(1'b1, cfg0, 32'h19, 1'b0);
      apb(1'b1, cfg31, 32'h1f5, 1'b0);
      apb(1'b1, `FTC_OFF_EXT_BASE, 32'h80000000, 1'b0);
      apb(1'b1, `FTC_OFF_EVT_MASK, 32'h1, 1'b0);
      apb(1'b1, `FTC_OFF_CTRL, 32'h1, 1'b0);
      ev(0, 5'h00, 3'h1, 32'h0);
      chk({31'h0, irq_o}, 32'h1);
      apb(1'b1, `FTC_OFF_EVT_MASK, 32'h0, 1'b0);
      chk({31'h0, irq_o}, 32'h0);
      apb(1'b1, `FTC_OFF_EVT_MASK, 32'h1, 1'b0);
      apb(1'b1, `FTC_OFF_EVT_STATUS, 32'h1, 1'b0);
      apb(1'b0, `FTC_OFF_EVT_STATUS, 32'h0, 1'b0);
      chk(rd & 32'h1, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      // New compensation lands at the next operation tick
      apb(1'b1, comp0, 32'h7fffffff, 1'b0);
      repeat (60) @(posedge sys_clk_i);
      ev(0, 5'h00, 3'h1, `FTC_COMP_MAX);
      apb(1'b1, comp0, -32'sh005b8d80, 1'b0);
      repeat (60) @(posedge sys_clk_i);
      ev(0, 5'h00, 3'h1, `FTC_COMP_MIN);
      for (int a = 2; a <= 5; a++) begin
         apb(1'b1, cfg0, 32'h18 | a, 1'b0);
         ev(0, 5'h00, a[2:0], `FTC_COMP_MIN);
      end
      apb(1'b1, `FTC_OFF_VALID_USED, 32'h1, 1'b0);
      apb(1'b1, `FTC_OFF_VALID, 32'h0, 1'b0);
      trig(0);
      wait_evt(4000, 1'b0);
      apb(1'b0, `FTC_OFF_IN_STATUS, 32'h0, 1'b0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, `FTC_OFF_VALID, 32'h1, 1'b0);
      ev(0, 5'h00, 3'h5, `FTC_COMP_MIN);
      // Falling edge must be seen while the pin is still low
      apb(1'b1, `FTC_OFF_EVT_STATUS, 32'h1, 1'b0);
      apb(1'b1, `FTC_OFF_EDGE_DIR, 32'h1, 1'b0);
      cmd[0] <= 1'b0;
      repeat (hold) @(posedge sys_clk_i);
      apb(1'b0, `FTC_OFF_EVT_STATUS, 32'h0, 1'b0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, `FTC_OFF_EDGE_DIR, 32'h0, 1'b0);
      cmd[0] <= 1'b1;
      wait_evt(8000, 1'b1);
      sync_i <= 1'b0;
      trig(0);
      wait_evt(4000, 1'b0);
      apb(1'b0, `FTC_OFF_VALID, 32'h0, 1'b0);
      chk(rd & 32'h1, 32'h0);
      sync_i <= 1'b1;
      slow <= 1'b1;
      // Slower add-on grid needs a longer pulse
      hold = 6000;
      apb(1'b1, `FTC_OFF_CTRL, 32'h3, 1'b0);
      trig(35);
      wait_evt(6000, 1'b0);
      apb(1'b1, `FTC_OFF_EXT_BASE, 32'h0, 1'b0);
      ev(35, 5'h1f, 3'h5, 32'h0);
      summarize();
   end
endmodule : fast_input_trigger_capture_bench
